// [verilog/lds_deserializer.sv]
`timescale 1ns/1ns
module lds_deserializer
   import lds_pkg::*;
#(
   parameter int LOCK_CYCLES = LOCK_CYC
) (
   input  wire logic            mclk_i,
   input  wire logic            rst_b_i,
   input  wire logic            link_clk_i,
   input  wire logic            link_clock_pos_i,
   input  wire logic            link_clock_neg_i,
   input  wire logic [3:0]      serial_lane_pos_i,
   input  wire logic [3:0]      serial_lane_neg_i,
   input  wire logic            sleep_n_i,
   input  wire logic            narrow_i,
   output lds_word_t            pixel_word_o,
   output lds_ctrl_t            pixel_ctrl_o,
   output logic                 pixel_clock_o
);

   // All checks run on the system clock and are quiet while reset is low.
   default clocking chk_clk @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);

   // ****************************************************************
   // Link domain: pin synchronisers
   // ****************************************************************
   logic [3:0]     lane_p_m_reg;
   logic [3:0]     lane_p_s_reg;
   logic [3:0]     lane_n_m_reg;
   logic [3:0]     lane_n_s_reg;
   logic           clk_p_m_reg;
   logic           clk_p_s_reg;
   logic           clk_n_m_reg;
   logic           clk_n_s_reg;
   logic           clk_lvl_d_reg;
   logic [2:0]     slot_reg;
   logic           done_reg;
   logic           tgl_reg;
   logic           clkv_reg;
   lds_word_t      asm_reg;
   lds_word_t      hold_reg;
   logic [3:0]     lane_bit;
   logic           clk_ok;
   logic           clk_lvl;
   logic           clk_rise;
   logic [2:0]     slot_cur;
   logic [2:0]     slot_next;

   always_ff @(posedge link_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         lane_p_m_reg <= 4'h0;
         lane_p_s_reg <= 4'h0;
         lane_n_m_reg <= 4'h0;
         lane_n_s_reg <= 4'h0;
         clk_p_m_reg  <= 1'b0;
         clk_p_s_reg  <= 1'b0;
         clk_n_m_reg  <= 1'b0;
         clk_n_s_reg  <= 1'b0;
      end else begin
         lane_p_m_reg <= serial_lane_pos_i;
         lane_p_s_reg <= lane_p_m_reg;
         lane_n_m_reg <= serial_lane_neg_i;
         lane_n_s_reg <= lane_n_m_reg;
         clk_p_m_reg  <= link_clock_pos_i;
         clk_p_s_reg  <= clk_p_m_reg;
         clk_n_m_reg  <= link_clock_neg_i;
         clk_n_s_reg  <= clk_n_m_reg;
      end
   end

   // ****************************************************************
   // Link domain: lane decode and slot framing
   // ****************************************************************
   // A pair with no differential level is floating or only terminated.
   always_comb begin
      for (int l = 0; l < LANES_WIDE; l++) begin
         lane_bit[l] = (lane_p_s_reg[l] == lane_n_s_reg[l]) ? 1'b1 : lane_p_s_reg[l];
      end
      clk_ok    = clk_p_s_reg ^ clk_n_s_reg;
      clk_lvl   = clk_p_s_reg & clk_ok;
      clk_rise  = clk_lvl & ~clk_lvl_d_reg;
      slot_cur  = clk_rise ? 3'h0 : slot_reg;
      slot_next = (slot_cur == SLOT_NONE) ? SLOT_NONE : slot_cur + 3'h1;
   end

   always_ff @(posedge link_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         clk_lvl_d_reg <= 1'b0;
         slot_reg      <= SLOT_NONE;
         clkv_reg      <= 1'b0;
      end else begin
         clk_lvl_d_reg <= clk_lvl;
         slot_reg      <= slot_next;
         clkv_reg      <= clk_ok;
      end
   end

   // Seven slots per lane are filled, then the word is parked for the other domain.
   always_ff @(posedge link_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         asm_reg  <= WORD_RST;
         done_reg <= 1'b0;
      end else begin
         if (slot_cur != SLOT_NONE) begin
            for (int l = 0; l < LANES_WIDE; l++) begin
               asm_reg.lane[l][slot_cur] <= lane_bit[l];
            end
         end
         done_reg <= (slot_cur == SLOT_LAST);
      end
   end

   // The parked word stays still for seven link edges, which covers the toggle sync delay.
   always_ff @(posedge link_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         hold_reg <= WORD_RST;
         tgl_reg  <= 1'b0;
      end else if (done_reg) begin
         hold_reg <= asm_reg;
         tgl_reg  <= ~tgl_reg;
      end
   end

   // ****************************************************************
   // System domain: synchronisers
   // ****************************************************************
   logic           sleep_m_reg;
   logic           sleep_s_reg;
   logic           narrow_m_reg;
   logic           narrow_s_reg;
   logic           clkv_m_reg;
   logic           clkv_s_reg;
   logic           tgl_m_reg;
   logic           tgl_s_reg;
   logic           tgl_d_reg;
   logic           evt;

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sleep_m_reg  <= 1'b0;
         sleep_s_reg  <= 1'b0;
         narrow_m_reg <= 1'b0;
         narrow_s_reg <= 1'b0;
         clkv_m_reg   <= 1'b0;
         clkv_s_reg   <= 1'b0;
         tgl_m_reg    <= 1'b0;
         tgl_s_reg    <= 1'b0;
         tgl_d_reg    <= 1'b0;
      end else begin
         sleep_m_reg  <= sleep_n_i;
         sleep_s_reg  <= sleep_m_reg;
         narrow_m_reg <= narrow_i;
         narrow_s_reg <= narrow_m_reg;
         clkv_m_reg   <= clkv_reg;
         clkv_s_reg   <= clkv_m_reg;
         tgl_m_reg    <= tgl_reg;
         tgl_s_reg    <= tgl_m_reg;
         tgl_d_reg    <= tgl_s_reg;
      end
   end

   assign evt = tgl_s_reg ^ tgl_d_reg;

   // ****************************************************************
   // Lock timer
   // ****************************************************************
   logic [19:0]    lock_cnt_reg;
   logic           locked_reg;

   // Losing the clock lane restarts the lock wait, as a real loop would relock.
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         lock_cnt_reg <= 20'h00000;
         locked_reg   <= 1'b0;
      end else if (!sleep_s_reg || !clkv_s_reg) begin
         lock_cnt_reg <= 20'h00000;
         locked_reg   <= 1'b0;
      end else if (!locked_reg) begin
         lock_cnt_reg <= lock_cnt_reg + 20'h00001;
         locked_reg   <= (lock_cnt_reg == 20'(LOCK_CYCLES - 1));
      end
   end

   // ****************************************************************
   // Pending word and two-entry buffer
   // ****************************************************************
   lds_word_t      pend_word_reg;
   logic           pend_reg;
   lds_word_t      fifo_mem [FIFO_DEPTH];
   logic           wp_reg;
   logic           rp_reg;
   logic [1:0]     fcnt_reg;
   logic           in_ready;
   logic           out_valid;
   logic           push;
   logic           pop;
   lds_out_state_t state_reg;

   assign in_ready  = (fcnt_reg != 2'(FIFO_DEPTH));
   assign out_valid = (fcnt_reg != 2'h0);
   assign push      = pend_reg & in_ready;
   assign pop       = out_valid & (state_reg == OS_IDLE) & locked_reg & sleep_s_reg & clkv_s_reg;

   // A full buffer holds the word here; only a further word in that wait is overwritten.
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pend_reg      <= 1'b0;
         pend_word_reg <= WORD_RST;
      end else if (!locked_reg) begin
         pend_reg      <= 1'b0;
      end else if (evt) begin
         pend_reg      <= 1'b1;
         pend_word_reg <= hold_reg;
      end else if (push) begin
         pend_reg      <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (push) begin
         fifo_mem[wp_reg] <= pend_word_reg;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wp_reg   <= 1'b0;
         rp_reg   <= 1'b0;
         fcnt_reg <= 2'h0;
      end else if (!locked_reg) begin
         wp_reg   <= 1'b0;
         rp_reg   <= 1'b0;
         fcnt_reg <= 2'h0;
      end else begin
         wp_reg   <= wp_reg ^ push;
         rp_reg   <= rp_reg ^ pop;
         fcnt_reg <= fcnt_reg + 2'(push) - 2'(pop);
      end
   end

   // ****************************************************************
   // Output stage
   // ****************************************************************
   // Data change with the rising pixel clock, so a full cycle of setup precedes the falling edge.
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pixel_word_o  <= WORD_RST;
         pixel_ctrl_o  <= CTRL_RST;
         pixel_clock_o <= 1'b0;
         state_reg     <= OS_IDLE;
      end else if (!sleep_s_reg) begin
         pixel_word_o  <= WORD_RST;
         pixel_ctrl_o  <= CTRL_RST;
         pixel_clock_o <= 1'b0;
         state_reg     <= OS_IDLE;
      end else begin
         case (state_reg)
            OS_IDLE: begin
               if (pop) begin
                  pixel_word_o  <= fifo_mem[rp_reg];
                  pixel_ctrl_o.line_sync   <= fifo_mem[rp_reg].lane[CTRL_LANE][LINE_POS];
                  pixel_ctrl_o.frame_sync  <= fifo_mem[rp_reg].lane[CTRL_LANE][FRAME_POS];
                  pixel_ctrl_o.pixel_valid <= fifo_mem[rp_reg].lane[CTRL_LANE][VALID_POS];
                  pixel_clock_o <= 1'b1;
                  state_reg     <= OS_STROBE;
               end
               // The unused lane is cleared only here, so a strap change never moves data under a strobe.
               if (narrow_s_reg) begin
                  pixel_word_o.lane[UNUSED_LANE] <= '0;
               end
            end
            OS_STROBE: begin
               pixel_clock_o <= 1'b0;
               state_reg     <= OS_IDLE;
            end
            default: begin
               pixel_clock_o <= 1'b0;
               state_reg     <= OS_IDLE;
            end
         endcase
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   chk_sleep_low: assert property (
      !sleep_s_reg |=> (pixel_word_o == WORD_RST) && (pixel_ctrl_o == CTRL_RST) && !pixel_clock_o)
      else $error("Outputs not low during sleep.");
   chk_sleep_delay: assert property (
      $fell(sleep_n_i) |-> ##[1:4] (!pixel_clock_o && (pixel_word_o == WORD_RST)))
      else $error("Sleep entry too slow.");
   chk_lock_count: assert property (
      $rose(locked_reg) |-> $past(lock_cnt_reg) == 20'(LOCK_CYCLES - 1))
      else $error("Lock reached at the wrong count.");
   chk_lock_first: assert property (
      $rose(pixel_clock_o) |-> $past(locked_reg) && $past(sleep_s_reg))
      else $error("Pixel clock toggled before lock.");
   chk_strobe_shape: assert property (
      ($rose(pixel_clock_o) && sleep_s_reg) |=> !pixel_clock_o && $stable(pixel_word_o))
      else $error("Word moved across the strobe edge.");
   chk_clock_lost: assert property (
      !clkv_s_reg |=> !pixel_clock_o)
      else $error("Pixel clock high without a link clock.");
   chk_hold_data: assert property (
      (sleep_s_reg && !clkv_s_reg && !narrow_s_reg) |=> $stable(pixel_word_o))
      else $error("Data moved without a link clock.");
   chk_narrow_zero: assert property (
      narrow_s_reg && $past(narrow_s_reg) |=> (pixel_word_o.lane[UNUSED_LANE] == '0))
      else $error("Unused lane driven in narrow mode.");
   chk_one_word: assert property (
      (pop && sleep_s_reg) |=> pixel_clock_o ##1 !pixel_clock_o)
      else $error("Popped word did not yield one strobe.");
   chk_fifo_bound: assert property (
      (fcnt_reg == 2'h2) |-> !push ##1 (fcnt_reg <= 2'h2))
      else $error("Buffer overfilled.");

endmodule : lds_deserializer

// [verilog/lds_pkg.sv]
package lds_pkg;

   // ****************************************************************
   // Link geometry
   // ****************************************************************
   localparam int LANES_WIDE    = 4;
   localparam int LANES_NARROW  = 3;
   localparam int BITS_PER_LANE = 7;
   localparam int WORD_W_WIDE   = 28;
   localparam int WORD_W_NARROW = 21;
   localparam int COLOUR_W_WIDE = 8;
   localparam int COLOUR_W_NAR  = 6;
   localparam int LINK_MIN_MHZ  = 20;
   localparam int LINK_MAX_MHZ  = 85;

   // ****************************************************************
   // Field positions of the sync and valid lines inside the control lane, the unused lane and the slot markers
   // ****************************************************************
   localparam int CTRL_LANE     = 2;
   localparam int LINE_POS      = 4;
   localparam int FRAME_POS     = 5;
   localparam int VALID_POS     = 6;
   localparam int UNUSED_LANE   = 3;
   localparam logic [2:0] SLOT_LAST = 3'h6;
   localparam logic [2:0] SLOT_NONE = 3'h7;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int MCLK_MHZ      = 100;
   localparam int LOCK_TIME_MS  = 10;
   localparam int LOCK_CYC      = LOCK_TIME_MS * 1000 * MCLK_MHZ;
   localparam int SLEEP_TIME_US = 1;
   localparam int SLEEP_CYC     = SLEEP_TIME_US * MCLK_MHZ;
   localparam int FIFO_DEPTH    = 2;

   // ****************************************************************
   // Carriers and states
   // ****************************************************************
   typedef struct packed {
      logic [LANES_WIDE-1:0][BITS_PER_LANE-1:0] lane;
   } lds_word_t;

   typedef struct packed {
      logic line_sync;
      logic frame_sync;
      logic pixel_valid;
   } lds_ctrl_t;

   typedef enum logic {
      OS_IDLE   = 1'b0,
      OS_STROBE = 1'b1
   } lds_out_state_t;

   localparam lds_word_t WORD_RST = '0;
   localparam lds_ctrl_t CTRL_RST = '0;

endpackage : lds_pkg

// [testbench/lds_tx_model.sv]
`timescale 1ns/1ns
// ****************************************************************
// Link transmitter model
// ****************************************************************
module lds_tx_model
   import lds_pkg::*;
(
   input  wire logic       link_clk_i,
   input  wire logic       rst_b_i,
   input  wire lds_word_t  word_i,
   input  wire logic [3:0] float_data_i,
   input  wire logic       float_clk_i,
   output logic [3:0]      lane_pos_o,
   output logic [3:0]      lane_neg_o,
   output logic            clk_pos_o,
   output logic            clk_neg_o
);
   logic [2:0] slot_reg;
   lds_word_t  frame_reg;

   // Seven slots per link clock period; the next word is taken only at a frame boundary.
   always_ff @(posedge link_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         slot_reg  <= 3'h0;
         frame_reg <= WORD_RST;
      end else if (slot_reg == SLOT_LAST) begin
         slot_reg  <= 3'h0;
         frame_reg <= word_i;
      end else begin
         slot_reg <= slot_reg + 3'h1;
      end
   end

   // An open pair is pulled high on both legs by the receiver's bias, so it reads as equal legs.
   always_comb begin
      for (int l = 0; l < LANES_WIDE; l++) begin
         lane_pos_o[l] = float_data_i[l] | frame_reg.lane[l][slot_reg];
         lane_neg_o[l] = float_data_i[l] | ~frame_reg.lane[l][slot_reg];
      end
      clk_pos_o = float_clk_i | (slot_reg < 3'h4);
      clk_neg_o = float_clk_i | (slot_reg >= 3'h4);
   end
endmodule : lds_tx_model

// [testbench/testbench.sv]
`timescale 1ns/1ns
module testbench
   import lds_pkg::*;
;
   typedef struct packed {
      lds_word_t  word;
      logic       narrow;
      logic [3:0] flt;
      lds_word_t  exp;
   } lds_row_t;

   logic       mclk_i, rst_b_i, link_clk_i, sleep_n_i, narrow_i, flt_clk, clk_pos, clk_neg, pix_clk;
   logic [3:0] flt_data, lane_pos, lane_neg;
   lds_word_t  word_tx, pix_word;
   lds_ctrl_t  pix_ctrl;
   int         err_total, n_tests, cnt;
   lds_row_t   rows [4] = '{'{28'hA5C3E17, 1'b0, 4'h0, 28'hA5C3E17},
                            '{28'h1234567, 1'b1, 4'h8, 28'h0034567},
                            '{28'h0000000, 1'b0, 4'h2, 28'h0003F80},
                            '{28'h5A3C1E8, 1'b0, 4'h0, 28'h5A3C1E8}};

   always #5 mclk_i = ~mclk_i;
   always #3 link_clk_i = ~link_clk_i;

   lds_tx_model u_lds_tx_model (
      .link_clk_i   (link_clk_i),
      .rst_b_i      (rst_b_i),
      .word_i       (word_tx),
      .float_data_i (flt_data),
      .float_clk_i  (flt_clk),
      .lane_pos_o   (lane_pos),
      .lane_neg_o   (lane_neg),
      .clk_pos_o    (clk_pos),
      .clk_neg_o    (clk_neg)
   );

   lds_deserializer #(.LOCK_CYCLES(20)) u_lds_deserializer (
      .mclk_i            (mclk_i),
      .rst_b_i           (rst_b_i),
      .link_clk_i        (link_clk_i),
      .link_clock_pos_i  (clk_pos),
      .link_clock_neg_i  (clk_neg),
      .serial_lane_pos_i (lane_pos),
      .serial_lane_neg_i (lane_neg),
      .sleep_n_i         (sleep_n_i),
      .narrow_i          (narrow_i),
      .pixel_word_o      (pix_word),
      .pixel_ctrl_o      (pix_ctrl),
      .pixel_clock_o     (pix_clk)
   );

   // ****************************************************************
   // Compare and closing tasks
   // ****************************************************************
   task automatic cmp_word(input string nm, input lds_word_t e, input lds_word_t g);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp_word

   task automatic cmp_ctrl(input string nm, input lds_ctrl_t e, input lds_ctrl_t g);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp_ctrl

   task automatic cmp_bit(input string nm, input logic e, input logic g);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
      end
   endtask : cmp_bit

   task automatic results;
      $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : results

   // Waits for the next pixel clock pulse; the word is read while the pulse is high.
   task automatic wait_strobe;
      int i;
      i = 0;
      @(negedge mclk_i);
      while (pix_clk !== 1'b1 && i < 300) begin
         @(negedge mclk_i);
         i++;
      end
      cmp_bit("strobe seen", 1'b1, pix_clk);
   endtask : wait_strobe

   function automatic lds_ctrl_t ctrl_of(input lds_word_t w);
      return '{w.lane[CTRL_LANE][LINE_POS], w.lane[CTRL_LANE][FRAME_POS], w.lane[CTRL_LANE][VALID_POS]};
   endfunction : ctrl_of

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      mclk_i = 0; link_clk_i = 1; rst_b_i = 0; sleep_n_i = 1; narrow_i = 0;
      word_tx = WORD_RST; flt_data = 4'h0; flt_clk = 0; err_total = 0; n_tests = 0;
      repeat (2) @(negedge mclk_i);
      cmp_word("word in reset", WORD_RST, pix_word);
      rst_b_i = 1;
      foreach (rows[i]) begin
         word_tx = rows[i].word;
         narrow_i = rows[i].narrow;
         flt_data = rows[i].flt;
         repeat (4) wait_strobe();
         cmp_word("row word", rows[i].exp, pix_word);
         cmp_ctrl("row ctrl", ctrl_of(rows[i].exp), pix_ctrl);
         @(negedge mclk_i);
         cmp_bit("clock falls", 1'b0, pix_clk);
         cmp_word("word at falling edge", rows[i].exp, pix_word);
      end
      cnt = 0;
      repeat (84) begin
         @(negedge mclk_i);
         cnt += (pix_clk === 1'b1);
      end
      cmp_bit("word rate", 1'b1, cnt >= 19 && cnt <= 21);
      // Sender loses power: the clock lane and all four data lanes go open; the word must survive it.
      flt_clk = 1;
      flt_data = 4'hF;
      repeat (5) @(negedge mclk_i);
      repeat (40) begin
         @(negedge mclk_i);
         cmp_bit("clock parked", 1'b0, pix_clk);
      end
      cmp_word("held word", rows[3].exp, pix_word);
      flt_clk = 0;
      flt_data = 4'h0;
      repeat (3) wait_strobe();
      cmp_word("word after relock", rows[3].exp, pix_word);
      @(negedge mclk_i);
      sleep_n_i = 0;
      repeat (3) @(negedge mclk_i);
      repeat (10) begin
         @(negedge mclk_i);
         cmp_word("sleep word", WORD_RST, pix_word);
         cmp_ctrl("sleep ctrl", CTRL_RST, pix_ctrl);
         cmp_bit("sleep clock", 1'b0, pix_clk);
      end
      sleep_n_i = 1;
      repeat (15) begin
         @(negedge mclk_i);
         cmp_bit("idle before lock", 1'b0, pix_clk);
      end
      repeat (2) wait_strobe();
      cmp_word("word after wake", rows[3].exp, pix_word);
      results();
   end

   // A hang is cut short well beyond the few hundred cycles the sequence needs.
   initial begin
      repeat (20000) @(posedge mclk_i);
      err_total++;
      results();
   end
endmodule : testbench
